// [rtl/fpacu_top.sv]
// Single-precision absolute, add, compare and conversion execution slice
// Notes on behaviour
// - Absolute value clears only the sign bit
// - Add writes sum of two operands
// - Add never touches status flags
// - Compare register or zero, set flags
// - Trapping compare: any NaN is invalid
// - Plain compare: only signaling NaN invalid
// - Float to int: zero or mode rounding
// - Int to float uses status rounding mode
// - 16-bit fixed source reads only low bits
// - Signed fixed result is sign-extended
// - Unsigned fixed result is zero-extended
// - To fixed truncates, from fixed nearest
// - Fixed conversion reuses one single register
// - Low half bits 15:0, high 31:16
// - Half to single fills whole destination
// - Single to half keeps other half
// - Runs only when unit enabled
`timescale 1ns/1ps
`include "fpacu_cfg.svh"

module fpacu_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  op_valid,
    input  wire fpacu_pkg::fpacu_op_e  op,
    input  wire logic                  cond_pass,
    input  wire logic                  fpu_enable,
    input  wire logic [31:0]           src_a,
    input  wire logic [31:0]           src_b,
    input  wire logic                  cmp_with_zero,
    input  wire logic                  integer_operand_type,
    input  wire logic [1:0]            fixed_point_type,
    input  wire logic [5:0]            frac_bits,
    input  wire logic [1:0]            round_mode,
    output logic                       res_done,
    output logic                       res_write,
    output logic [31:0]                res_data,
    output logic                       flag_write,
    output logic [3:0]                 flag_nzcv,
    output logic                       invalid_op,
    output logic                       op_refused
);

    // ------------------------------------------------------------------
    // Format helpers
    // ------------------------------------------------------------------

    // Significand with hidden bit
    function automatic logic [23:0] f_sig(input logic [31:0] x);
        f_sig = {|x[30:23], x[22:0]};
    endfunction

    // Weight of significand lsb as a power of two
    function automatic integer f_exp(input logic [31:0] x);
        if (x[30:23] == 8'h00) begin
            f_exp = -`FPACU_S_SUB_LSB;
        end else begin
            f_exp = int'(x[30:23]) - `FPACU_S_LSB_OFS;
        end
    endfunction

    // Any NaN
    function automatic logic f_nan(input logic [31:0] x);
        f_nan = (&x[30:23]) & (|x[22:0]);
    endfunction

    // Signaling NaN: quiet bit clear
    function automatic logic f_snan(input logic [31:0] x);
        f_snan = f_nan(x) & ~x[22];
    endfunction

    // Infinity
    function automatic logic f_inf(input logic [31:0] x);
        f_inf = (&x[30:23]) & ~(|x[22:0]);
    endfunction

    // Round-up decision from lsb, guard and sticky
    function automatic logic f_rinc(input logic [1:0] md, input logic sg,
                                    input logic lb, input logic g, input logic st);
        case (md)
            `FPACU_RM_NEAR:  f_rinc = g & (st | lb);
            `FPACU_RM_PLUS:  f_rinc = ~sg & (g | st);
            `FPACU_RM_MINUS: f_rinc = sg & (g | st);
            default:         f_rinc = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Rounder and packer: value is mag times two to the e
    // ------------------------------------------------------------------
    function automatic logic [31:0] f_pack(input logic sg, input logic [63:0] mag,
                                           input integer e, input logic [1:0] md,
                                           input logic hlf);
        integer      p;
        integer      mb;
        integer      bias;
        integer      lsbe;
        integer      sh;
        integer      bexp;
        integer      i;
        logic [63:0] kept;
        logic        g;
        logic        st;
        logic [25:0] m;
        mb   = hlf ? `FPACU_H_MB : `FPACU_S_MB;
        bias = hlf ? `FPACU_H_BIAS : `FPACU_S_BIAS;
        p    = -1;
        g    = 1'b0;
        st   = 1'b0;
        // Leading one position
        for (i = 0; i < 64; i++) begin
            if (mag[i]) p = i;
        end
        // Lsb weight of the result, floored at the subnormal lsb
        lsbe = p + e - mb;
        if (lsbe < 1 - bias - mb) lsbe = 1 - bias - mb;
        sh = lsbe - e;
        if (sh <= 0) begin
            kept = mag << (-sh);
        end else begin
            kept = mag >> sh;
        end
        // Guard and sticky from the bits shifted out
        for (i = 0; i < 64; i++) begin
            if (i == sh - 1) g = mag[i];
            if (i < sh - 1) st = st | mag[i];
        end
        m    = kept[25:0] + {25'h0, f_rinc(md, sg, kept[0], g, st)};
        bexp = lsbe + mb + bias;
        // Carry out of rounding, or subnormal result
        if (m[mb+1]) begin
            m    = m >> 1;
            bexp = bexp + 1;
        end else if (!m[mb]) begin
            bexp = 0;
        end
        // Exact zero keeps its sign
        if (p < 0) begin
            m    = '0;
            bexp = 0;
        end
        // Overflow: infinity or largest finite by direction
        if (bexp >= 2 * bias + 1) begin
            if ((md == `FPACU_RM_ZERO) || ((md == `FPACU_RM_PLUS) && sg)
                || ((md == `FPACU_RM_MINUS) && !sg)) begin
                bexp = 2 * bias;
                m    = '1;
            end else begin
                bexp = 2 * bias + 1;
                m    = '0;
            end
        end
        if (hlf) begin
            f_pack = {16'h0, sg, bexp[4:0], m[9:0]};
        end else begin
            f_pack = {sg, bexp[7:0], m[22:0]};
        end
    endfunction

    // ------------------------------------------------------------------
    // Single-precision add with alignment guard bits
    // ------------------------------------------------------------------
    function automatic logic [31:0] f_add(input logic [31:0] a, input logic [31:0] b,
                                          input logic [1:0] md);
        integer      d;
        logic [31:0] bg;
        logic [31:0] sm;
        logic [63:0] mbig;
        logic [63:0] msml;
        logic [63:0] mal;
        logic [63:0] mag;
        logic        sg;
        // Larger magnitude leads
        bg   = (b[30:0] > a[30:0]) ? b : a;
        sm   = (b[30:0] > a[30:0]) ? a : b;
        d    = f_exp(bg) - f_exp(sm);
        mbig = {40'h0, f_sig(bg)} << `FPACU_ADD_GUARD;
        msml = {40'h0, f_sig(sm)} << `FPACU_ADD_GUARD;
        mal  = msml >> d;
        // Bits lost in alignment fold into a sticky lsb
        mal[0] = mal[0] | ((mal << d) != msml);
        mag  = (a[31] == b[31]) ? (mbig + mal) : (mbig - mal);
        sg   = bg[31];
        // Exact cancellation gives minus zero only rounding down
        if ((mag == 64'h0) && (a[31] != b[31])) sg = (md == `FPACU_RM_MINUS);
        if (f_nan(a) || f_nan(b) || (f_inf(a) && f_inf(b) && (a[31] != b[31]))) begin
            f_add = `FPACU_QNAN_S;
        end else if (f_inf(a)) begin
            f_add = a;
        end else if (f_inf(b)) begin
            f_add = b;
        end else begin
            f_add = f_pack(sg, mag, f_exp(bg) - `FPACU_ADD_GUARD, md, 1'b0);
        end
    endfunction

    // ------------------------------------------------------------------
    // Float to integer or fixed point, saturating
    // ------------------------------------------------------------------
    function automatic logic [31:0] f_tofix(input logic [31:0] x, input integer fb,
                                            input logic w32, input logic sgd,
                                            input logic [1:0] md);
        integer      sh;
        integer      i;
        logic [63:0] v;
        logic [63:0] lim;
        logic        g;
        logic        st;
        logic [23:0] sgx;
        g   = 1'b0;
        st  = 1'b0;
        sgx = f_sig(x);
        sh  = f_exp(x) + fb;
        if (sh >= 0) begin
            v = (sh > `FPACU_FIX_SAT) ? '1 : ({40'h0, f_sig(x)} << sh);
        end else begin
            v = {40'h0, f_sig(x)} >> (-sh);
            for (i = 0; i < 64; i++) begin
                if (i == -sh - 1) g = sgx[i % 24] & (i < 24);
                if (i < -sh - 1) st = st | (sgx[i % 24] & (i < 24));
            end
            v = v + {63'h0, f_rinc(md, x[31], v[0], g, st)};
        end
        if (&x[30:23]) v = '1;
        // Largest positive magnitude of the target type
        lim = ((64'h1 << (w32 ? `FPACU_FIX_W32 : `FPACU_HALF_W)) >> sgd) - 64'h1;
        if (f_nan(x)) begin
            f_tofix = '0;
        end else if (!x[31]) begin
            f_tofix = (v > lim) ? lim[31:0] : v[31:0];
        end else if (!sgd) begin
            f_tofix = '0;
        end else begin
            f_tofix = (v > lim + 64'h1) ? ~lim[31:0] : (~v[31:0] + 32'h1);
        end
    endfunction

    // ------------------------------------------------------------------
    // Integer or fixed point to float
    // ------------------------------------------------------------------
    function automatic logic [31:0] f_fromfix(input logic [31:0] src, input integer fb,
                                              input logic w32, input logic sgd,
                                              input logic [1:0] md);
        logic [31:0] v;
        logic        ng;
        // Only the low half counts for 16-bit sources
        if (w32) begin
            v = src;
        end else begin
            v = sgd ? {{16{src[15]}}, src[15:0]} : {16'h0, src[15:0]};
        end
        ng = sgd & v[`FPACU_SIGN_BIT];
        f_fromfix = f_pack(ng, {32'h0, ng ? (~v + 32'h1) : v}, -fb, md, 1'b0);
    endfunction

    // ------------------------------------------------------------------
    // Half to single, always exact
    // ------------------------------------------------------------------
    function automatic logic [31:0] f_h2s(input logic [15:0] h);
        integer e;
        e = (h[14:10] == 5'h00) ? -`FPACU_H_SUB_LSB : int'(h[14:10]) - `FPACU_H_LSB_OFS;
        if (&h[14:10]) begin
            f_h2s = {h[15], 8'hFF, (|h[9:0]), h[8:0], 13'h0};
        end else begin
            f_h2s = f_pack(h[15], {53'h0, |h[14:10], h[9:0]}, e, `FPACU_RM_NEAR, 1'b0);
        end
    endfunction

    // Single to half with status rounding
    function automatic logic [15:0] f_s2h(input logic [31:0] x, input logic [1:0] md);
        logic [31:0] r;
        r = f_pack(x[31], {40'h0, f_sig(x)}, f_exp(x), md, 1'b1);
        if (f_nan(x)) begin
            f_s2h = {x[31], 5'h1F, 1'b1, x[21:13]};
        end else if (f_inf(x)) begin
            f_s2h = {x[31], 5'h1F, 10'h0};
        end else begin
            f_s2h = r[15:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Datapath and state
    // ------------------------------------------------------------------
    fpacu_pkg::fpacu_state_s st_ff;      // Registered outputs
    fpacu_pkg::fpacu_state_s nxt_st;     // Next value
    logic                    take;       // Op executes this cycle
    logic [31:0]             cmp_b;      // Second compare operand
    logic                    any_nan;    // Either compare operand NaN
    logic                    any_snan;   // Either compare operand signaling
    logic [31:0]             key_a;      // Ordered compare keys
    logic [31:0]             key_b;
    logic                    fix_w32;    // Fixed type width 32
    logic                    fix_sgd;    // Fixed type signed

    assign take     = op_valid & fpu_enable & cond_pass;
    assign cmp_b    = cmp_with_zero ? 32'h0 : src_b;
    assign any_nan  = f_nan(src_a) | f_nan(cmp_b);
    assign any_snan = f_snan(src_a) | f_snan(cmp_b);
    assign key_a    = src_a[31] ? ~src_a : {1'b1, src_a[30:0]};
    assign key_b    = cmp_b[31] ? ~cmp_b : {1'b1, cmp_b[30:0]};
    assign fix_w32  = fixed_point_type[1];
    assign fix_sgd  = fixed_point_type[0];

    // Next-state: one result per accepted op
    always_comb begin
        nxt_st      = '0;
        nxt_st.data = st_ff.data;
        // Unit disabled: refuse, touch nothing
        if (op_valid && !fpu_enable) begin
            nxt_st.refused = 1'b1;
        end else if (op_valid) begin
            nxt_st.done = 1'b1;
        end
        // Failed condition falls through with no writes
        if (take) begin
            nxt_st.wr = 1'b1;
            unique case (op)
                fpacu_pkg::fp_absolute_op: begin
                    nxt_st.data = {1'b0, src_b[30:0]};
                end
                fpacu_pkg::fp_add_op: begin
                    nxt_st.data = f_add(src_a, src_b, round_mode);
                end
                fpacu_pkg::fp_compare_op, fpacu_pkg::fp_compare_nan_trap_op: begin
                    nxt_st.wr     = 1'b0;
                    nxt_st.flg_wr = 1'b1;
                    if (any_nan) begin
                        nxt_st.nzcv = `FPACU_NZCV_UN;
                    end else if ((key_a == key_b) || ((src_a[30:0] == 31'h0)
                                 && (cmp_b[30:0] == 31'h0))) begin
                        nxt_st.nzcv = `FPACU_NZCV_EQ;
                    end else if (key_a < key_b) begin
                        nxt_st.nzcv = `FPACU_NZCV_LT;
                    end else begin
                        nxt_st.nzcv = `FPACU_NZCV_GT;
                    end
                    nxt_st.inv = any_snan
                        | ((op == fpacu_pkg::fp_compare_nan_trap_op) & any_nan);
                end
                fpacu_pkg::fp_convert_op: begin
                    nxt_st.data = f_tofix(src_b, 0, 1'b1, integer_operand_type,
                                          `FPACU_RM_ZERO);
                end
                fpacu_pkg::fp_to_int_mode_round_op: begin
                    nxt_st.data = f_tofix(src_b, 0, 1'b1, integer_operand_type,
                                          round_mode);
                end
                fpacu_pkg::int_to_fp_op: begin
                    nxt_st.data = f_fromfix(src_b, 0, 1'b1, integer_operand_type,
                                            round_mode);
                end
                fpacu_pkg::fp_to_fixed_op: begin
                    // Same register in and out, truncating
                    nxt_st.data = f_tofix(src_a, int'(frac_bits), fix_w32, fix_sgd,
                                          `FPACU_RM_ZERO);
                end
                fpacu_pkg::fixed_to_fp_op: begin
                    nxt_st.data = f_fromfix(src_a, int'(frac_bits), fix_w32, fix_sgd,
                                            `FPACU_RM_NEAR);
                end
                fpacu_pkg::half_convert_low_op: begin
                    nxt_st.data = f_h2s(src_b[15:0]);
                end
                fpacu_pkg::half_convert_high_op: begin
                    nxt_st.data = f_h2s(src_b[31:16]);
                end
                fpacu_pkg::single_to_half_low_op: begin
                    nxt_st.data = {src_a[31:16], f_s2h(src_b, round_mode)};
                end
                fpacu_pkg::single_to_half_high_op: begin
                    nxt_st.data = {f_s2h(src_b, round_mode), src_a[15:0]};
                end
                default: begin
                    // Unknown code: no write
                    nxt_st.wr = 1'b0;
                end
            endcase
        end
    end

    // State register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flops
    assign res_done   = st_ff.done;
    assign res_write  = st_ff.wr;
    assign res_data   = st_ff.data;
    assign flag_write = st_ff.flg_wr;
    assign flag_nzcv  = st_ff.nzcv;
    assign invalid_op = st_ff.inv;
    assign op_refused = st_ff.refused;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_abs_sign: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::fp_absolute_op)
        |-> res_write && (res_data == ($past(src_b) & ~(32'h1 << `FPACU_SIGN_BIT))))
        else $error("absolute result wrong");
    chk_add_noflag: assert property (!$past(rst) && $past(op_valid)
        && ($past(op) == fpacu_pkg::fp_add_op) |-> !flag_write && !invalid_op)
        else $error("add touched flags");
    chk_cmp_flags: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::fp_compare_op) |-> flag_write && !res_write)
        else $error("compare flags not written");
    chk_cmpe_nan: assert property (!$past(rst) && $past(take) && $past(any_nan)
        && ($past(op) == fpacu_pkg::fp_compare_nan_trap_op)
        |-> invalid_op && (flag_nzcv == `FPACU_NZCV_UN))
        else $error("trapping compare missed NaN");
    chk_cmp_quiet: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::fp_compare_op)
        |-> (invalid_op == $past(any_snan)))
        else $error("plain compare invalid wrong");
    chk_fix_sext: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::fp_to_fixed_op) && ($past(fixed_point_type) == 2'h1)
        |-> (res_data[31:16] == {16{res_data[15]}}))
        else $error("signed fixed not extended");
    chk_fix_zext: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::fp_to_fixed_op) && ($past(fixed_point_type) == 2'h0)
        |-> (res_data[31:16] == 16'h0))
        else $error("unsigned fixed not zero");
    chk_half_keep: assert property (!$past(rst) && $past(take)
        && ($past(op) == fpacu_pkg::single_to_half_low_op)
        |-> (res_data[31:16] == $past(src_a[31:16])))
        else $error("half store lost other half");
    chk_cond_fail: assert property (!$past(rst) && $past(op_valid)
        && !$past(cond_pass) |-> !res_write && !flag_write && !invalid_op
        && $stable(res_data))
        else $error("failed condition wrote state");
    chk_disabled: assert property (!$past(rst) && $past(op_valid)
        && !$past(fpu_enable) |-> op_refused && !res_done && !res_write)
        else $error("disabled unit executed");

endmodule

// [inc/fpacu_cfg.svh]
// Numeric constants of the floating-point add, compare and convert slice
`ifndef FPACU_CFG_SVH
`define FPACU_CFG_SVH

// ----------------------------------------------------------------------
// Rounding mode codes as held in the status register
// ----------------------------------------------------------------------
`define FPACU_RM_NEAR   2'h0
`define FPACU_RM_PLUS   2'h1
`define FPACU_RM_MINUS  2'h2
`define FPACU_RM_ZERO   2'h3

// ----------------------------------------------------------------------
// Field positions and format figures
// ----------------------------------------------------------------------
`define FPACU_SIGN_BIT  31
`define FPACU_HALF_W    16
`define FPACU_S_BIAS    127
`define FPACU_H_BIAS    15
`define FPACU_S_MB      23
`define FPACU_H_MB      10
`define FPACU_S_LSB_OFS 150
`define FPACU_S_SUB_LSB 149
`define FPACU_H_LSB_OFS 25
`define FPACU_H_SUB_LSB 24
`define FPACU_ADD_GUARD 30
`define FPACU_FIX_SAT   40
`define FPACU_FIX_W32   32

// ----------------------------------------------------------------------
// Result constants
// ----------------------------------------------------------------------
`define FPACU_QNAN_S    32'h7FC00000
`define FPACU_NZCV_LT   4'h8
`define FPACU_NZCV_EQ   4'h6
`define FPACU_NZCV_GT   4'h2
`define FPACU_NZCV_UN   4'h3

`endif

// [inc/fpacu_pkg.sv]
// Types shared by the floating-point add, compare and convert slice
package fpacu_pkg;

    // Operation codes from the issue logic
    typedef enum logic [3:0] {
        fp_absolute_op          = 4'h0,
        fp_add_op               = 4'h1,
        fp_compare_op           = 4'h2,
        fp_compare_nan_trap_op  = 4'h3,
        fp_convert_op           = 4'h4,
        fp_to_int_mode_round_op = 4'h5,
        int_to_fp_op            = 4'h6,
        fp_to_fixed_op          = 4'h7,
        fixed_to_fp_op          = 4'h8,
        half_convert_low_op     = 4'h9,
        half_convert_high_op    = 4'hA,
        single_to_half_low_op   = 4'hB,
        single_to_half_high_op  = 4'hC
    } fpacu_op_e;

    // Whole registered state of the slice
    typedef struct packed {
        logic        done;
        logic        wr;
        logic [31:0] data;
        logic        flg_wr;
        logic [3:0]  nzcv;
        logic        inv;
        logic        refused;
    } fpacu_state_s;

endpackage

// [testbench/fpacu_rf_model.sv]
// Register file and core flag model beside the slice
`timescale 1ns/1ps
module fpacu_rf_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        res_write,
    input  wire logic [31:0] res_data,
    input  wire logic        flag_write,
    input  wire logic [3:0]  flag_nzcv,
    output logic      [31:0] dst_ff,
    output logic      [3:0]  core_nzcv_ff
);
    // Capture results; flags copied to core as a status move does
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dst_ff       <= 32'h0;
            core_nzcv_ff <= 4'h0;
        end else begin
            if (res_write) dst_ff <= res_data;
            if (flag_write) core_nzcv_ff <= flag_nzcv;
        end
    end
endmodule

// [testbench/tb_fpacu_top.sv]
// Self-checking bench for the execution slice
`timescale 1ns/1ps
module tb_fpacu_top;
    logic ref_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, cp = 1'b1, en = 1'b1;
    logic cz = 1'b0, it = 1'b0, res_done, res_write, flag_write, invalid_op, op_refused;
    logic [1:0] ft = 2'h0, rm = 2'h0;
    logic [5:0] fb = 6'h00;
    logic [3:0] flag_nzcv;
    logic [3:0] rf_nzcv;
    logic [31:0] rf_dst;
    logic [31:0] src_a = 32'h0, src_b = 32'h0, res_data;
    fpacu_pkg::fpacu_op_e op = fpacu_pkg::fp_absolute_op;
    int errors = 0, n_tests = 0;
    localparam logic [8:0] W = 9'h180;
    // Clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;
    fpacu_top uut (.ref_clk, .rst, .op_valid, .op, .cond_pass(cp), .fpu_enable(en),
        .src_a, .src_b, .cmp_with_zero(cz), .integer_operand_type(it),
        .fixed_point_type(ft), .frac_bits(fb), .round_mode(rm), .res_done, .res_write,
        .res_data, .flag_write, .flag_nzcv, .invalid_op, .op_refused);
    fpacu_rf_model prt (.ref_clk, .rst, .res_write, .res_data, .flag_write, .flag_nzcv,
        .dst_ff(rf_dst), .core_nzcv_ff(rf_nzcv));
    // Expected compare outcome: done, flag write, flags, invalid
    function automatic logic [8:0] c(input logic [3:0] n, input logic i);
        return {3'h5, n, i, 1'b0};
    endfunction
    // Issue one op back to back, judge the answer one cycle later
    task automatic x(input logic [3:0] o, input logic [31:0] a, b, d, input logic [8:0] e);
        op_valid = 1'b1;
        op = fpacu_pkg::fpacu_op_e'(o);
        src_a = a;
        src_b = b;
        @(negedge ref_clk);
        n_tests++;
        if ({res_done, res_write, flag_write, flag_nzcv, invalid_op, op_refused} !== e
            || (e[7] && res_data !== d)) begin
            errors++;
            $display("[ERR] %0t bad answer to op %h", $time, o);
        end
    endtask
    // Destination and core flags as the partner last captured them
    task automatic chk_rf(input logic [31:0] d, input logic [3:0] n);
        n_tests++;
        if (rf_dst !== d || rf_nzcv !== n) begin
            errors++;
            $display("[ERR] %0t register file model mismatch", $time);
        end
    endtask
    task automatic s_arith;
        x(4'h0, 32'h0, 32'hBF800000, 32'h3F800000, W);
        x(4'h1, 32'h3F800000, 32'h3F800000, 32'h40000000, W);
    endtask
    task automatic s_cmp;
        x(4'h2, 32'h3F800000, 32'h40000000, 32'h0, c(4'h8, 1'b0));
        cz = 1'b1;
        x(4'h2, 32'hBF800000, 32'h0, 32'h0, c(4'h8, 1'b0));
        x(4'h2, 32'h80000000, 32'h3F800000, 32'h0, c(4'h6, 1'b0));
        cz = 1'b0;
        x(4'h2, 32'h7FC00000, 32'h3F800000, 32'h0, c(4'h3, 1'b0));
        chk_rf(32'h40000000, 4'h6);
        x(4'h3, 32'h7FC00000, 32'h3F800000, 32'h0, c(4'h3, 1'b1));
        x(4'h2, 32'h3F800000, 32'h7F800001, 32'h0, c(4'h3, 1'b1));
    endtask
    task automatic s_int;
        rm = 2'h1;
        x(4'h4, 32'h0, 32'h40200000, 32'h2, W);
        x(4'h5, 32'h0, 32'h40200000, 32'h3, W);
        x(4'h6, 32'h0, 32'h01000001, 32'h4B800001, W);
        rm = 2'h0;
        x(4'h5, 32'h0, 32'h40200000, 32'h2, W);
        x(4'h6, 32'h0, 32'h01000001, 32'h4B800000, W);
        it = 1'b1;
        x(4'h6, 32'h0, 32'h3, 32'h40400000, W);
        rm = 2'h2;
        x(4'h5, 32'h0, 32'hC0200000, 32'hFFFFFFFD, W);
        rm = 2'h0;
    endtask
    task automatic s_fix;
        ft = 2'h1;
        x(4'h7, 32'hC0000000, 32'h0, 32'hFFFFFFFE, W);
        x(4'h8, 32'hABCD0004, 32'h0, 32'h40800000, W);
        ft = 2'h0;
        fb = 6'h01;
        x(4'h7, 32'h3FE00000, 32'h0, 32'h3, W);
        ft = 2'h2;
        rm = 2'h3;
        x(4'h8, 32'h01000003, 32'h0, 32'h4B000002, W);
        ft = 2'h3;
        x(4'h7, 32'hBFC00000, 32'h0, 32'hFFFFFFFD, W);
        rm = 2'h0;
    endtask
    task automatic s_half;
        x(4'h9, 32'h0, 32'h40003C00, 32'h3F800000, W);
        x(4'hA, 32'h0, 32'h40003C00, 32'h40000000, W);
        x(4'hB, 32'h12345678, 32'h3F800000, 32'h12343C00, W);
        x(4'hC, 32'h12345678, 32'h3F800000, 32'h3C005678, W);
    endtask
    task automatic s_gate;
        cp = 1'b0;
        x(4'h3, 32'h7FC00000, 32'h0, 32'h0, 9'h100);
        cp = 1'b1;
        en = 1'b0;
        x(4'h1, 32'h3F800000, 32'h3F800000, 32'h0, 9'h001);
        op_valid = 1'b0;
    endtask
    task automatic close_out;
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reset, then scenarios back to back
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        s_arith();
        s_cmp();
        s_int();
        s_fix();
        s_half();
        s_gate();
        close_out();
    end
endmodule
